// ==== hdl/dftr_pkg.sv ====
package dftr_pkg;

  // Clock and timing
  localparam longint CLK_HZ         = 100_000_000;
  localparam longint STOP_TEST_S    = 100;
  localparam logic [35:0] STOP_TEST_CYC = 36'(STOP_TEST_S * CLK_HZ);
  localparam longint RESTART_US     = 500;
  localparam logic [35:0] RESTART_CYC =
    36'((RESTART_US * CLK_HZ) / 1_000_000);
  localparam logic [3:0] PWRUP_CYC  = 4'h8;

  // Register byte addresses
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_INIT   = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_NEWEST = 8'h0C;
  localparam logic [7:0] ADR_MIDDLE = 8'h10;
  localparam logic [7:0] ADR_OLDEST = 8'h14;

  // Field positions and reset values
  localparam int        CTRL_USP_BIT   = 0;
  localparam logic      USP_EN_RST     = 1'b1;
  localparam logic [7:0] INIT_SEL_RST  = 8'h01;
  localparam logic [7:0] INIT_CLR_HIST = 8'h00;
  localparam int        ST_STATE_LSB   = 8;
  localparam int        ST_TRIP_BIT    = 11;

  // Motion phase encoding
  localparam logic [1:0] PH_CONST = 2'h0;
  localparam logic [1:0] PH_DECEL = 2'h1;
  localparam logic [1:0] PH_ACCEL = 2'h2;

  // Error codes shown on the display
  localparam logic [7:0] EC_NONE     = 8'h00;
  localparam logic [7:0] EC_OC_CONST = 8'h01;
  localparam logic [7:0] EC_OC_DECEL = 8'h02;
  localparam logic [7:0] EC_OC_ACCEL = 8'h03;
  localparam logic [7:0] EC_OC_OTHER = 8'h04;
  localparam logic [7:0] EC_OVERLOAD = 8'h05;
  localparam logic [7:0] EC_BRAKE    = 8'h06;
  localparam logic [7:0] EC_OVERVOLT = 8'h07;
  localparam logic [7:0] EC_NVMEM    = 8'h08;
  localparam logic [7:0] EC_UNDERV   = 8'h09;
  localparam logic [7:0] EC_CPU_A    = 8'h11;
  localparam logic [7:0] EC_EXT      = 8'h12;
  localparam logic [7:0] EC_START    = 8'h13;
  localparam logic [7:0] EC_GROUND   = 8'h14;
  localparam logic [7:0] EC_IN_OV    = 8'h15;
  localparam logic [7:0] EC_THERMAL  = 8'h21;
  localparam logic [7:0] EC_CPU_B    = 8'h22;
  localparam logic [7:0] EC_GATE     = 8'h23;
  localparam logic [7:0] EC_THERMIST = 8'h35;
  localparam logic [7:0] EC_COMM     = 8'h60;

  typedef enum logic [2:0] {
    ST_POWERUP = 3'b000,
    ST_STOP    = 3'b001,
    ST_RUN     = 3'b010,
    ST_RESTART = 3'b011,
    ST_TRIP    = 3'b100
  } dftr_state_t;

endpackage

// ==== hdl/dftr_sync.sv ====
`timescale 1ns/1ps
module dftr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  // Levels in and out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          s1_q        <= 1'b0;
          s2_q        <= 1'b0;
          s3_q        <= 1'b0;
          sync_out[gi] <= 1'b0;
        end else begin
          s1_q <= async_in[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // Accept a change only once the last two stages agree
          if (s2_q == s3_q) begin
            sync_out[gi] <= s3_q;
          end
        end
      end
    end
  endgenerate

endmodule

// ==== hdl/dftr_top.sv ====
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Any trip: output off, history recorded
// - Stop/reset key clears an active trip
// - Init select 00 erases fault history only
// - Trip shows its error code automatically
// - Over-current coded by motion phase
// - Motor overload trips with overload code
// - Braking resistor overload trips, output off
// - DC bus over-voltage gives over-voltage code
// - Parameter memory fault trips with memory code
// - DC bus under-voltage trips, under-voltage code
// - Processor malfunction trips with either code
// - External trip input trips the device
// - Start guard: run at power-up trips
// - Power-up ground fault check trips
// - Input over-voltage tested after stop dwell
// - Power module over-temperature trips
// - Gate array link failure reported
// - External thermistor over-temperature trips
// - Network watchdog expiry trips
// - Low input: off, retry, else trip
// - Reset terminal at power loss: memory error
// - Three-deep history shifts newest to oldest
module dftr_top #(
  parameter logic [35:0] STOP_TEST_CYC = dftr_pkg::STOP_TEST_CYC,
  parameter logic [35:0] RESTART_CYC   = dftr_pkg::RESTART_CYC,
  parameter int          PERF_W        = 16
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // Fault sensing pins
  input  wire logic              over_current,
  input  wire logic [1:0]        motion_phase,
  input  wire logic              motor_overload,
  input  wire logic              brake_overload,
  input  wire logic              dc_over_volt,
  input  wire logic              nvmem_fault,
  input  wire logic              dc_under_volt,
  input  wire logic              cpu_fault_a,
  input  wire logic              cpu_fault_b,
  input  wire logic              external_trip_input,
  input  wire logic              ground_fault,
  input  wire logic              input_over_volt,
  input  wire logic              module_over_temp,
  input  wire logic              gate_link_fail,
  input  wire logic              thermistor_hot,
  input  wire logic              comm_watchdog_expired,
  input  wire logic              low_input_volt,
  // Operator and terminal pins
  input  wire logic              run_command,
  input  wire logic              stop_reset_key,
  input  wire logic              reset_input_terminal,
  // Same-clock inputs
  input  wire logic              nv_reset_at_powerdown,
  input  wire logic [PERF_W-1:0] perf_data,
  // Drive and display
  output logic                   power_out_en,
  output logic                   trip_alarm,
  output logic                   restart_active,
  output logic      [7:0]        display_code,
  output logic                   reset_term_level
);

  localparam int HW = PERF_W + 8;
  localparam int SW = 21;

  logic [SW-1:0]       pins_raw;
  logic [SW-1:0]       pins_s;
  logic                s_oc;
  logic [1:0]          s_phase;
  logic                s_movl;
  logic                s_bovl;
  logic                s_dcov;
  logic                s_nvm;
  logic                s_dcuv;
  logic                s_cpua;
  logic                s_cpub;
  logic                s_ext;
  logic                s_gf;
  logic                s_inov;
  logic                s_mhot;
  logic                s_gate;
  logic                s_therm;
  logic                s_wdt;
  logic                s_low;
  logic                s_run;
  logic                s_key;
  logic                s_rs;

  dftr_pkg::dftr_state_t state_q;
  dftr_pkg::dftr_state_t state_d;
  logic                usp_en_q;
  logic [7:0]          init_sel_q;
  logic [3:0]          pwr_cnt_q;
  logic [35:0]         stop_cnt_q;
  logic [35:0]         rst_cnt_q;
  logic                key_q;
  logic                key_edge;
  logic                stop_test_ok;
  logic                fault_hit;
  logic [7:0]          fault_code;
  logic                trip_now;
  logic                hist_clr;
  logic [HW-1:0]       hist_q [3];

  assign pins_raw = {over_current, motion_phase, motor_overload,
                     brake_overload, dc_over_volt, nvmem_fault,
                     dc_under_volt, cpu_fault_a, cpu_fault_b,
                     external_trip_input, ground_fault, input_over_volt,
                     module_over_temp, gate_link_fail, thermistor_hot,
                     comm_watchdog_expired, low_input_volt, run_command,
                     stop_reset_key, reset_input_terminal};

  dftr_sync #(
    .W (SW)
  ) u_sync (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  assign {s_oc, s_phase, s_movl, s_bovl, s_dcov, s_nvm, s_dcuv, s_cpua,
          s_cpub, s_ext, s_gf, s_inov, s_mhot, s_gate, s_therm, s_wdt,
          s_low, s_run, s_key, s_rs} = pins_s;

  assign key_edge     = s_key & ~key_q;
  assign stop_test_ok = (stop_cnt_q >= STOP_TEST_CYC);

  // Operating faults, highest priority first
  always_comb begin
    fault_hit  = 1'b1;
    fault_code = dftr_pkg::EC_NONE;
    if (s_oc) begin
      case (s_phase)
        dftr_pkg::PH_CONST: fault_code = dftr_pkg::EC_OC_CONST;
        dftr_pkg::PH_DECEL: fault_code = dftr_pkg::EC_OC_DECEL;
        dftr_pkg::PH_ACCEL: fault_code = dftr_pkg::EC_OC_ACCEL;
        default:            fault_code = dftr_pkg::EC_OC_OTHER;
      endcase
    end else if (s_movl) begin
      fault_code = dftr_pkg::EC_OVERLOAD;
    end else if (s_bovl) begin
      fault_code = dftr_pkg::EC_BRAKE;
    end else if (s_dcov) begin
      fault_code = dftr_pkg::EC_OVERVOLT;
    end else if (s_nvm) begin
      fault_code = dftr_pkg::EC_NVMEM;
    end else if (s_dcuv) begin
      fault_code = dftr_pkg::EC_UNDERV;
    end else if (s_cpua) begin
      fault_code = dftr_pkg::EC_CPU_A;
    end else if (s_cpub) begin
      fault_code = dftr_pkg::EC_CPU_B;
    end else if (s_ext) begin
      fault_code = dftr_pkg::EC_EXT;
    end else if (s_mhot) begin
      fault_code = dftr_pkg::EC_THERMAL;
    end else if (s_gate) begin
      fault_code = dftr_pkg::EC_GATE;
    end else if (s_therm) begin
      fault_code = dftr_pkg::EC_THERMIST;
    end else if (s_wdt) begin
      fault_code = dftr_pkg::EC_COMM;
    end else if (state_q == dftr_pkg::ST_STOP && stop_test_ok && s_inov) begin
      fault_code = dftr_pkg::EC_IN_OV;
    end else if (state_q == dftr_pkg::ST_RESTART && s_low &&
                 rst_cnt_q >= RESTART_CYC) begin
      fault_code = dftr_pkg::EC_UNDERV;
    end else begin
      fault_hit = 1'b0;
    end
  end

  // Next state and trip decision
  always_comb begin
    state_d    = state_q;
    trip_now   = 1'b0;
    case (state_q)
      dftr_pkg::ST_POWERUP: begin
        if (pwr_cnt_q >= dftr_pkg::PWRUP_CYC) begin
          if (fault_hit || s_gf || nv_reset_at_powerdown ||
              (usp_en_q && s_run)) begin
            trip_now = 1'b1;
            state_d  = dftr_pkg::ST_TRIP;
          end else begin
            state_d = dftr_pkg::ST_STOP;
          end
        end
      end
      dftr_pkg::ST_STOP: begin
        if (fault_hit) begin
          trip_now = 1'b1;
          state_d  = dftr_pkg::ST_TRIP;
        end else if (s_run && !s_key) begin
          state_d = dftr_pkg::ST_RUN;
        end
      end
      dftr_pkg::ST_RUN: begin
        if (fault_hit) begin
          trip_now = 1'b1;
          state_d  = dftr_pkg::ST_TRIP;
        end else if (s_low) begin
          state_d = dftr_pkg::ST_RESTART;
        end else if (key_edge || !s_run) begin
          state_d = dftr_pkg::ST_STOP;
        end
      end
      dftr_pkg::ST_RESTART: begin
        if (fault_hit) begin
          trip_now = 1'b1;
          state_d  = dftr_pkg::ST_TRIP;
        end else if (!s_low) begin
          state_d = s_run ? dftr_pkg::ST_RUN : dftr_pkg::ST_STOP;
        end
      end
      dftr_pkg::ST_TRIP: begin
        // Run is refused here until the operator clears the trip
        if (key_edge) begin
          state_d = dftr_pkg::ST_STOP;
        end
      end
      default: begin
        state_d = dftr_pkg::ST_POWERUP;
      end
    endcase
  end

  // Power-up code for the trip taken at the end of the check window
  logic [7:0] trip_code;
  always_comb begin
    trip_code = fault_code;
    if (state_q == dftr_pkg::ST_POWERUP && !fault_hit) begin
      if (s_gf) begin
        trip_code = dftr_pkg::EC_GROUND;
      end else if (nv_reset_at_powerdown) begin
        trip_code = dftr_pkg::EC_NVMEM;
      end else begin
        trip_code = dftr_pkg::EC_START;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q <= dftr_pkg::ST_POWERUP;
      key_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      key_q   <= s_key;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pwr_cnt_q <= 4'h0;
    end else if (state_q == dftr_pkg::ST_POWERUP) begin
      pwr_cnt_q <= pwr_cnt_q + 4'h1;
    end
  end

  // Stop dwell counter saturates once the test is armed
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      stop_cnt_q <= 36'h0;
    end else if (state_q != dftr_pkg::ST_STOP) begin
      stop_cnt_q <= 36'h0;
    end else if (!stop_test_ok) begin
      stop_cnt_q <= stop_cnt_q + 36'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rst_cnt_q <= 36'h0;
    end else if (state_q != dftr_pkg::ST_RESTART) begin
      rst_cnt_q <= 36'h0;
    end else if (rst_cnt_q < RESTART_CYC) begin
      rst_cnt_q <= rst_cnt_q + 36'h1;
    end
  end

  // Drive and display outputs
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      power_out_en     <= 1'b0;
      trip_alarm       <= 1'b0;
      restart_active   <= 1'b0;
      display_code     <= dftr_pkg::EC_NONE;
      reset_term_level <= 1'b0;
    end else begin
      power_out_en     <= (state_d == dftr_pkg::ST_RUN);
      trip_alarm       <= (state_d == dftr_pkg::ST_TRIP);
      restart_active   <= (state_d == dftr_pkg::ST_RESTART);
      reset_term_level <= s_rs;
      if (trip_now) begin
        display_code <= trip_code;
      end else if (state_d != dftr_pkg::ST_TRIP) begin
        display_code <= dftr_pkg::EC_NONE;
      end
    end
  end

  // Fault history: a new entry wins over a clear in the same cycle
  assign hist_clr = reg_wr && reg_addr == dftr_pkg::ADR_INIT &&
                    reg_wdata[7:0] == dftr_pkg::INIT_CLR_HIST;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      for (int i = 0; i < 3; i++) begin
        hist_q[i] <= '0;
      end
    end else if (trip_now) begin
      hist_q[0] <= {perf_data, trip_code};
      hist_q[1] <= hist_clr ? '0 : hist_q[0];
      hist_q[2] <= hist_clr ? '0 : hist_q[1];
    end else if (hist_clr) begin
      for (int i = 0; i < 3; i++) begin
        hist_q[i] <= '0;
      end
    end
  end
  // A trip clear touches only state and display, never hist_q

  // Configuration registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      usp_en_q   <= dftr_pkg::USP_EN_RST;
      init_sel_q <= dftr_pkg::INIT_SEL_RST;
    end else if (reg_wr) begin
      if (reg_addr == dftr_pkg::ADR_CTRL) begin
        usp_en_q <= reg_wdata[dftr_pkg::CTRL_USP_BIT];
      end
      if (reg_addr == dftr_pkg::ADR_INIT) begin
        init_sel_q <= reg_wdata[7:0];
      end
    end
  end

  // Read data, valid the cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      reg_rdata <= 32'h0;
      case (reg_addr)
        dftr_pkg::ADR_CTRL: begin
          reg_rdata[dftr_pkg::CTRL_USP_BIT] <= usp_en_q;
        end
        dftr_pkg::ADR_INIT: begin
          reg_rdata[7:0] <= init_sel_q;
        end
        dftr_pkg::ADR_STATUS: begin
          reg_rdata[7:0] <= display_code;
          reg_rdata[dftr_pkg::ST_STATE_LSB +: 3] <= state_q;
          reg_rdata[dftr_pkg::ST_TRIP_BIT] <= trip_alarm;
        end
        dftr_pkg::ADR_NEWEST: begin
          reg_rdata[HW-1:0] <= hist_q[0];
        end
        dftr_pkg::ADR_MIDDLE: begin
          reg_rdata[HW-1:0] <= hist_q[1];
        end
        dftr_pkg::ADR_OLDEST: begin
          reg_rdata[HW-1:0] <= hist_q[2];
        end
        default: begin
          reg_rdata <= 32'h0;
        end
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

endmodule

// ==== test/dftr_partner.sv ====
`timescale 1ns/1ps
module dftr_partner (
  // Clock
  input  wire logic        ref_clk,
  // Requests from the bench
  input  wire logic [15:0] fault_req,
  input  wire logic [1:0]  phase_req,
  input  wire logic        key_req,
  // Pins toward the block
  output logic      [15:0] fault_pins,
  output logic      [1:0]  motion_phase,
  output logic             stop_reset_key
);
  logic [15:0] pins_q  = 16'h0;
  logic [1:0]  phase_q = 2'h0;
  logic [3:0]  key_q   = 4'h0;
  // Sense sources change only on the clock, one cycle after a request
  always_ff @(posedge ref_clk) begin
    pins_q  <= fault_req;
    phase_q <= phase_req;
  end
  // A press is held long enough to pass the input filter
  always_ff @(posedge ref_clk) begin
    if (key_req) begin
      key_q <= 4'h8;
    end else if (key_q != 4'h0) begin
      key_q <= key_q - 4'h1;
    end
  end
  assign fault_pins     = pins_q;
  assign motion_phase   = phase_q;
  assign stop_reset_key = (key_q != 4'h0);
endmodule

// ==== test/dftr_assertions.sv ====
`timescale 1ns/1ps
module dftr_assertions #(
  parameter logic [35:0] RESTART_CYC = dftr_pkg::RESTART_CYC
) (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       external_trip_input,
  input wire logic       stop_reset_key,
  input wire logic       power_out_en,
  input wire logic       trip_alarm,
  input wire logic       restart_active,
  input wire logic [7:0] display_code
);
  localparam logic [35:0] LIM = RESTART_CYC + 36'h8;
  logic [35:0] rcnt_q;
  always_ff @(posedge ref_clk) begin
    if (!resetn || !restart_active) begin
      rcnt_q <= 36'h0;
    end else begin
      rcnt_q <= rcnt_q + 36'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_trip_off;
    trip_alarm |-> !power_out_en;
  endproperty
  a_trip_off: assert property (p_trip_off)
    else $error("output on while tripped");
  property p_code;
    trip_alarm == (display_code != dftr_pkg::EC_NONE);
  endproperty
  a_code: assert property (p_code)
    else $error("display code does not follow trip");
  property p_ext;
    external_trip_input [*8] |-> ##[0:8] trip_alarm;
  endproperty
  a_ext: assert property (p_ext)
    else $error("external trip not taken");
  property p_key;
    $rose(stop_reset_key) && trip_alarm |-> ##[1:12] !trip_alarm;
  endproperty
  a_key: assert property (p_key)
    else $error("key did not clear trip");
  property p_stable;
    trip_alarm && $past(trip_alarm) |-> $stable(display_code);
  endproperty
  a_stable: assert property (p_stable)
    else $error("code changed while tripped");
  property p_rst_off;
    restart_active |-> !power_out_en && !trip_alarm;
  endproperty
  a_rst_off: assert property (p_rst_off)
    else $error("output on during restart");
  property p_rst_len;
    rcnt_q <= LIM;
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("restart attempt too long");
  property p_uv;
    $rose(trip_alarm) && $past(restart_active)
      |-> display_code == dftr_pkg::EC_UNDERV;
  endproperty
  a_uv: assert property (p_uv)
    else $error("failed restart not under-voltage");
endmodule

bind dftr_top dftr_assertions #(.RESTART_CYC(RESTART_CYC)) u_chk (
  .ref_clk(ref_clk), .resetn(resetn),
  .external_trip_input(external_trip_input),
  .stop_reset_key(stop_reset_key), .power_out_en(power_out_en),
  .trip_alarm(trip_alarm), .restart_active(restart_active),
  .display_code(display_code)
);

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  localparam logic [3:0] FB [16] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h2,
    4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hB, 4'hC, 4'hD, 4'hE};
  localparam logic [7:0] FC [16] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
    8'h06, 8'h07, 8'h08, 8'h09, 8'h11, 8'h22, 8'h12, 8'h21, 8'h23, 8'h35,
    8'h60};
  logic        ref_clk   = 1'b0;
  logic        resetn    = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] fault_req = 16'h0;
  logic [1:0]  phase_req = 2'h0;
  logic        key_req   = 1'b0;
  logic        run_cmd   = 1'b1;
  logic        rs_term   = 1'b0;
  logic        nv_rst    = 1'b0;
  logic [15:0] perf      = 16'h0;
  logic [31:0] reg_rdata;
  logic [15:0] fpin;
  logic [1:0]  phase;
  logic        key, pwr_en, trip, rst_act, rs_lvl;
  logic [7:0]  dcode;
  int          errors    = 0;
  int          tests_run = 0;

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  dftr_partner u_far (
    .ref_clk(ref_clk), .fault_req(fault_req), .phase_req(phase_req),
    .key_req(key_req), .fault_pins(fpin), .motion_phase(phase),
    .stop_reset_key(key)
  );

  dftr_top #(.STOP_TEST_CYC(36'h32), .RESTART_CYC(36'h14), .PERF_W(16)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .over_current(fpin[0]), .motion_phase(phase),
    .motor_overload(fpin[1]), .brake_overload(fpin[2]),
    .dc_over_volt(fpin[3]), .nvmem_fault(fpin[4]),
    .dc_under_volt(fpin[5]), .cpu_fault_a(fpin[6]), .cpu_fault_b(fpin[7]),
    .external_trip_input(fpin[8]), .ground_fault(fpin[9]),
    .input_over_volt(fpin[10]), .module_over_temp(fpin[11]),
    .gate_link_fail(fpin[12]), .thermistor_hot(fpin[13]),
    .comm_watchdog_expired(fpin[14]), .low_input_volt(fpin[15]),
    .run_command(run_cmd), .stop_reset_key(key),
    .reset_input_terminal(rs_term), .nv_reset_at_powerdown(nv_rst),
    .perf_data(perf), .power_out_en(pwr_en), .trip_alarm(trip),
    .restart_active(rst_act), .display_code(dcode),
    .reset_term_level(rs_lvl)
  );

  task automatic end_sim();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    resetn <= 1'b0;
    cyc(5);
    resetn <= 1'b1;
  endtask

  task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_rd_t(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wait_trip(input logic lvl, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      if (trip === lvl) break;
      @(posedge ref_clk);
      #1;
    end
    if (trip !== lvl) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, trip, lvl);
      end_sim();
    end
  endtask

  task automatic press_key();
    @(posedge ref_clk);
    key_req <= 1'b1;
    @(posedge ref_clk);
    key_req <= 1'b0;
    wait_trip(1'b0, 30);
    cyc(15);
    #1;
  endtask

  task automatic t_usp();
    logic [31:0] d;
    wait_trip(1'b1, 40);
    check(32'(dcode), 32'h13);
    cyc(10);
    #1;
    check(32'(pwr_en), 32'h0);
    reg_rd_t(dftr_pkg::ADR_STATUS, d);
    check(d, 32'hC13);
    reg_rd_t(dftr_pkg::ADR_NEWEST, d);
    check(d, 32'h13);
    press_key();
    check(32'(pwr_en), 32'h1);
    reg_rd_t(dftr_pkg::ADR_STATUS, d);
    check(d, 32'h200);
    reg_rd_t(dftr_pkg::ADR_NEWEST, d);
    check(d, 32'h13);
  endtask

  task automatic t_codes();
    logic [31:0] d, p1, p2, e;
    int i;
    p1 = 32'h13;
    p2 = 32'h0;
    for (i = 0; i < 16; i++) begin
      check(32'(pwr_en), 32'h1);
      @(posedge ref_clk);
      perf      <= 16'(i + 1);
      phase_req <= (i < 4) ? 2'(i) : 2'h0;
      fault_req <= 16'h1 << FB[i];
      e = {8'h00, 16'(i + 1), FC[i]};
      wait_trip(1'b1, 40);
      check(32'(dcode), 32'(FC[i]));
      check(32'(pwr_en), 32'h0);
      reg_rd_t(dftr_pkg::ADR_NEWEST, d);
      check(d, e);
      reg_rd_t(dftr_pkg::ADR_MIDDLE, d);
      check(d, p1);
      reg_rd_t(dftr_pkg::ADR_OLDEST, d);
      check(d, p2);
      p2 = p1;
      p1 = e;
      @(posedge ref_clk);
      fault_req <= 16'h0;
      press_key();
    end
  endtask

  task automatic t_hist_clear();
    logic [31:0] d;
    int i;
    reg_wr_t(dftr_pkg::ADR_INIT, 32'h0);
    for (i = 0; i < 3; i++) begin
      reg_rd_t(dftr_pkg::ADR_NEWEST + 8'(4 * i), d);
      check(d, 32'h0);
    end
    reg_rd_t(dftr_pkg::ADR_CTRL, d);
    check(d, 32'h1);
    cyc(1);
    #1;
    check(reg_rdata, 32'h0);
    reg_rd_t(8'h20, d);
    check(d, 32'h0);
  endtask

  task automatic t_restart();
    @(posedge ref_clk);
    fault_req <= 16'h8000;
    rs_term   <= 1'b1;
    cyc(9);
    #1;
    check(32'(rst_act), 32'h1);
    check(32'(pwr_en), 32'h0);
    check(32'(rs_lvl), 32'h1);
    @(posedge ref_clk);
    fault_req <= 16'h0;
    rs_term   <= 1'b0;
    cyc(12);
    #1;
    check(32'(trip), 32'h0);
    check(32'(pwr_en), 32'h1);
    check(32'(rs_lvl), 32'h0);
    @(posedge ref_clk);
    fault_req <= 16'h8000;
    wait_trip(1'b1, 60);
    check(32'(dcode), 32'h09);
    @(posedge ref_clk);
    fault_req <= 16'h0;
    press_key();
  endtask

  task automatic t_in_ov();
    @(posedge ref_clk);
    run_cmd   <= 1'b0;
    fault_req <= 16'h0400;
    cyc(30);
    #1;
    check(32'(trip), 32'h0);
    wait_trip(1'b1, 60);
    check(32'(dcode), 32'h15);
    @(posedge ref_clk);
    fault_req <= 16'h0;
    run_cmd   <= 1'b1;
    press_key();
    check(32'(pwr_en), 32'h1);
  endtask

  task automatic t_powerup();
    @(posedge ref_clk);
    run_cmd   <= 1'b0;
    fault_req <= 16'h0200;
    do_reset();
    wait_trip(1'b1, 40);
    check(32'(dcode), 32'h14);
    @(posedge ref_clk);
    fault_req <= 16'h0;
    press_key();
    @(posedge ref_clk);
    nv_rst <= 1'b1;
    do_reset();
    wait_trip(1'b1, 40);
    check(32'(dcode), 32'h08);
  endtask

  initial begin
    do_reset();
    t_usp();
    t_codes();
    t_hist_clear();
    t_restart();
    t_in_ov();
    t_powerup();
    end_sim();
  end
endmodule
